// file: hdl/uiec_cfg.svh
`ifndef UIEC_CFG_SVH
`define UIEC_CFG_SVH

// indirect access register layout
`define UIEC_ADR_BUSY_BIT 7
`define UIEC_ADR_READ_BIT 6
`define UIEC_ADR_TGT_W 6

// usb register targets
`define UIEC_REG_INDEX 6'h0E
`define UIEC_REG_IN_LOW 6'h11
`define UIEC_REG_IN_HIGH 6'h12
`define UIEC_REG_OUT_LOW 6'h14
`define UIEC_REG_OUT_HIGH 6'h15

// endpoint selector
`define UIEC_INDEX_RESET 4'h0
`define UIEC_EP_FIRST 4'h1
`define UIEC_EP_COUNT 3

// in control low fields
`define UIEC_LO_PKT_READY 0
`define UIEC_LO_NOT_EMPTY 1
`define UIEC_LO_FLUSH 3
`define UIEC_LO_SEND_STALL 4
`define UIEC_LO_STALL_SENT 5

// in control high fields
`define UIEC_HI_SPLIT 2
`define UIEC_HI_FORCE_TOGGLE 3
`define UIEC_HI_DIRECTION 5
`define UIEC_HI_ISO 6
`define UIEC_HI_DBUF 7
`define UIEC_HI_MASK 8'hEC
`define UIEC_HI_RESET 8'h00
`define UIEC_OUT_RESET 8'h00

`endif

// file: hdl/uiec_pkg.sv
package uiec_pkg;

   typedef enum logic [1:0] {
      UIEC_TX_NAK = 2'b00,
      UIEC_TX_DATA = 2'b01,
      UIEC_TX_ZLP = 2'b10,
      UIEC_TX_STALL = 2'b11
   } uiec_tx_t;

   typedef enum logic [1:0] {
      UIEC_ACC_IDLE = 2'b00,
      UIEC_ACC_READ = 2'b01,
      UIEC_ACC_WRITE = 2'b10
   } uiec_acc_t;

endpackage

// file: hdl/uiec_ep.sv
`timescale 1ns/1ps
`default_nettype none
`include "uiec_cfg.svh"

module uiec_ep
   import uiec_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_low,
   input wire logic wr_high,
   input wire logic wr_out_low,
   input wire logic wr_out_high,
   input wire logic [7:0] wdata,
   input wire logic fifo_loaded,
   input wire logic token,
   input wire logic ack,
   output logic [7:0] low_rd,
   output logic [7:0] high_rd,
   output logic [7:0] out_low_rd,
   output logic [7:0] out_high_rd,
   output logic in_en,
   output logic out_en,
   output uiec_tx_t tx,
   output logic tx_toggle,
   output logic irq
);

   logic [1:0] cnt_ff, nxt_cnt;
   logic [1:0] zlp_ff, nxt_zlp;
   logic [7:0] high_ff, nxt_high;
   logic [7:0] out_low_ff, nxt_out_low;
   logic [7:0] out_high_ff, nxt_out_high;
   logic send_stall_ff, nxt_send_stall;
   logic stall_sent_ff, nxt_stall_sent;
   logic toggle_ff, nxt_toggle;
   logic await_ff, nxt_await;
   logic [1:0] cap;
   logic pop;
   logic push;
   logic [1:0] after_pop;

   always_comb begin
      cap = high_ff[`UIEC_HI_DBUF] ? 2'd2 : 2'd1;
      nxt_high = high_ff;
      nxt_out_low = out_low_ff;
      nxt_out_high = out_high_ff;
      nxt_send_stall = send_stall_ff;
      nxt_stall_sent = stall_sent_ff;
      nxt_toggle = toggle_ff;
      nxt_await = await_ff;
      tx = UIEC_TX_NAK;
      tx_toggle = toggle_ff;
      irq = 1'b0;
      pop = 1'b0;
      push = 1'b0;
      if (wr_high) begin
         nxt_high = wdata & `UIEC_HI_MASK;
      end
      if (wr_out_low) begin
         nxt_out_low = wdata;
      end
      if (wr_out_high) begin
         nxt_out_high = wdata;
      end
      if (wr_low) begin
         nxt_send_stall = wdata[`UIEC_LO_SEND_STALL];
         if (!wdata[`UIEC_LO_STALL_SENT]) begin
            nxt_stall_sent = 1'b0;
         end
      end
      if (token) begin
         if (send_stall_ff) begin
            tx = UIEC_TX_STALL;
            nxt_stall_sent = 1'b1;
            irq = 1'b1;
         end else if (cnt_ff != 2'd0) begin
            tx = zlp_ff[0] ? UIEC_TX_ZLP : UIEC_TX_DATA;
            pop = 1'b1;
            irq = 1'b1;
            if (high_ff[`UIEC_HI_ISO]) begin
               nxt_await = 1'b0;
            end else if (high_ff[`UIEC_HI_FORCE_TOGGLE]) begin
               nxt_toggle = ~toggle_ff;
               nxt_await = 1'b0;
            end else begin
               nxt_await = 1'b1;
            end
         end
      end
      if (ack && await_ff && !token) begin
         nxt_toggle = ~toggle_ff;
         nxt_await = 1'b0;
      end
      if (wr_low && wdata[`UIEC_LO_FLUSH] && cnt_ff != 2'd0 && !pop) begin
         pop = 1'b1;
         irq = 1'b1;
      end
      // a commit while the queue is full is dropped, as firmware must wait for ready low
      if (wr_low && wdata[`UIEC_LO_PKT_READY] && cnt_ff < cap) begin
         push = 1'b1;
      end
      after_pop = pop ? cnt_ff - 2'd1 : cnt_ff;
      nxt_zlp = pop ? {1'b0, zlp_ff[1]} : zlp_ff;
      if (push) begin
         nxt_zlp[after_pop[0]] = ~fifo_loaded;
      end
      nxt_cnt = push ? after_pop + 2'd1 : after_pop;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= 2'd0;
         zlp_ff <= 2'd0;
         high_ff <= `UIEC_HI_RESET;
         out_low_ff <= `UIEC_OUT_RESET;
         out_high_ff <= `UIEC_OUT_RESET;
         send_stall_ff <= 1'b0;
         stall_sent_ff <= 1'b0;
         toggle_ff <= 1'b0;
         await_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         zlp_ff <= nxt_zlp;
         high_ff <= nxt_high;
         out_low_ff <= nxt_out_low;
         out_high_ff <= nxt_out_high;
         send_stall_ff <= nxt_send_stall;
         stall_sent_ff <= nxt_stall_sent;
         toggle_ff <= nxt_toggle;
         await_ff <= nxt_await;
      end
   end

   always_comb begin
      low_rd = 8'h00;
      low_rd[`UIEC_LO_PKT_READY] = (cnt_ff == cap);
      low_rd[`UIEC_LO_NOT_EMPTY] = (cnt_ff != 2'd0);
      low_rd[`UIEC_LO_SEND_STALL] = send_stall_ff;
      low_rd[`UIEC_LO_STALL_SENT] = stall_sent_ff;
   end

   assign high_rd = high_ff;
   assign out_low_rd = out_low_ff;
   assign out_high_rd = out_high_ff;
   assign in_en = high_ff[`UIEC_HI_SPLIT] | high_ff[`UIEC_HI_DIRECTION];
   assign out_en = high_ff[`UIEC_HI_SPLIT] | ~high_ff[`UIEC_HI_DIRECTION];

endmodule

`default_nettype wire

// file: hdl/uiec_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "uiec_cfg.svh"

module uiec_top
   import uiec_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic adr_wr,
   input wire logic dat_wr,
   input wire logic [7:0] wdata,
   output logic [7:0] adr_rd_ff,
   output logic [7:0] dat_rd_ff,
   input wire logic in_token,
   input wire logic [3:0] in_token_ep,
   input wire logic host_ack,
   input wire logic [2:0] fifo_loaded,
   output logic tx_valid_ff,
   output uiec_tx_t tx_kind_ff,
   output logic [1:0] tx_ep_ff,
   output logic tx_toggle_ff,
   output logic [2:0] ep_int_ff,
   output logic [2:0] in_en_ff,
   output logic [2:0] out_en_ff
);

   logic rst_meta_ff;
   logic rst_n_ff;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_ff <= 1'b0;
         rst_n_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n_ff <= rst_meta_ff;
      end
   end

   uiec_acc_t acc_ff, nxt_acc;
   logic [`UIEC_ADR_TGT_W-1:0] target_ff, nxt_target;
   logic [7:0] wbuf_ff, nxt_wbuf;
   logic [7:0] nxt_dat_rd;
   logic [3:0] index_ff, nxt_index;
   logic [1:0] last_ep_ff, nxt_last_ep;
   logic nxt_tx_valid;
   uiec_tx_t nxt_tx_kind;
   logic [1:0] nxt_tx_ep;
   logic nxt_tx_toggle;

   logic [2:0] wr_low, wr_high, wr_out_low, wr_out_high;
   logic [2:0] tok, ack, ep_irq, ep_tog, ep_in, ep_out;
   logic [7:0] low_rd [3];
   logic [7:0] high_rd [3];
   logic [7:0] out_low_rd [3];
   logic [7:0] out_high_rd [3];
   uiec_tx_t ep_tx [3];

   logic sel_ok;
   logic [1:0] sel;
   logic wr_go;

   assign sel_ok = (index_ff >= `UIEC_EP_FIRST) && (index_ff < `UIEC_EP_FIRST + 4'd3);
   assign sel = 2'(index_ff - `UIEC_EP_FIRST);
   assign wr_go = (acc_ff == UIEC_ACC_WRITE);

   genvar g;
   generate
      for (g = 0; g < `UIEC_EP_COUNT; g++) begin : gen_ep
         // only the selected endpoint sees register writes
         assign wr_low[g] = wr_go && sel_ok && sel == 2'(g) && target_ff == `UIEC_REG_IN_LOW;
         assign wr_high[g] = wr_go && sel_ok && sel == 2'(g) && target_ff == `UIEC_REG_IN_HIGH;
         assign wr_out_low[g] = wr_go && sel_ok && sel == 2'(g) && target_ff == `UIEC_REG_OUT_LOW;
         assign wr_out_high[g] = wr_go && sel_ok && sel == 2'(g) && target_ff == `UIEC_REG_OUT_HIGH;
         assign tok[g] = in_token && in_token_ep == `UIEC_EP_FIRST + 4'(g) && ep_in[g];
         assign ack[g] = host_ack && last_ep_ff == 2'(g);
         uiec_ep u_ep (
            .clk(clk),
            .rst_n(rst_n_ff),
            .wr_low(wr_low[g]),
            .wr_high(wr_high[g]),
            .wr_out_low(wr_out_low[g]),
            .wr_out_high(wr_out_high[g]),
            .wdata(wbuf_ff),
            .fifo_loaded(fifo_loaded[g]),
            .token(tok[g]),
            .ack(ack[g]),
            .low_rd(low_rd[g]),
            .high_rd(high_rd[g]),
            .out_low_rd(out_low_rd[g]),
            .out_high_rd(out_high_rd[g]),
            .in_en(ep_in[g]),
            .out_en(ep_out[g]),
            .tx(ep_tx[g]),
            .tx_toggle(ep_tog[g]),
            .irq(ep_irq[g])
         );
      end
   endgenerate

   // indirect access engine; writes while busy are dropped
   always_comb begin
      nxt_acc = UIEC_ACC_IDLE;
      nxt_target = target_ff;
      nxt_wbuf = wbuf_ff;
      nxt_dat_rd = dat_rd_ff;
      nxt_index = index_ff;
      case (acc_ff)
         UIEC_ACC_IDLE: begin
            if (adr_wr) begin
               nxt_target = wdata[`UIEC_ADR_TGT_W-1:0];
               if (wdata[`UIEC_ADR_READ_BIT]) begin
                  nxt_acc = UIEC_ACC_READ;
               end
            end else if (dat_wr) begin
               nxt_wbuf = wdata;
               nxt_acc = UIEC_ACC_WRITE;
            end
         end
         UIEC_ACC_READ: begin
            case (target_ff)
               `UIEC_REG_INDEX: nxt_dat_rd = {4'h0, index_ff};
               `UIEC_REG_IN_LOW: nxt_dat_rd = sel_ok ? low_rd[sel] : 8'h00;
               `UIEC_REG_IN_HIGH: nxt_dat_rd = sel_ok ? high_rd[sel] : 8'h00;
               `UIEC_REG_OUT_LOW: nxt_dat_rd = sel_ok ? out_low_rd[sel] : 8'h00;
               `UIEC_REG_OUT_HIGH: nxt_dat_rd = sel_ok ? out_high_rd[sel] : 8'h00;
               default: nxt_dat_rd = 8'h00;
            endcase
         end
         UIEC_ACC_WRITE: begin
            if (target_ff == `UIEC_REG_INDEX) begin
               nxt_index = wbuf_ff[3:0];
            end
         end
         default: nxt_acc = UIEC_ACC_IDLE;
      endcase
   end

   // one endpoint can answer per token, so the first hit wins
   always_comb begin
      nxt_tx_valid = 1'b0;
      nxt_tx_kind = UIEC_TX_NAK;
      nxt_tx_ep = 2'd0;
      nxt_tx_toggle = 1'b0;
      nxt_last_ep = last_ep_ff;
      for (int i = 0; i < `UIEC_EP_COUNT; i++) begin
         if (tok[i] && !nxt_tx_valid) begin
            nxt_tx_valid = 1'b1;
            nxt_tx_kind = ep_tx[i];
            nxt_tx_ep = 2'(i);
            nxt_tx_toggle = ep_tog[i];
            if (ep_tx[i] == UIEC_TX_DATA || ep_tx[i] == UIEC_TX_ZLP) begin
               nxt_last_ep = 2'(i);
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         acc_ff <= UIEC_ACC_IDLE;
         target_ff <= '0;
         wbuf_ff <= 8'h00;
         dat_rd_ff <= 8'h00;
         index_ff <= `UIEC_INDEX_RESET;
         last_ep_ff <= 2'd0;
         tx_valid_ff <= 1'b0;
         tx_kind_ff <= UIEC_TX_NAK;
         tx_ep_ff <= 2'd0;
         tx_toggle_ff <= 1'b0;
         ep_int_ff <= 3'h0;
         in_en_ff <= 3'h0;
         out_en_ff <= 3'h0;
         adr_rd_ff <= 8'h00;
      end else begin
         acc_ff <= nxt_acc;
         target_ff <= nxt_target;
         wbuf_ff <= nxt_wbuf;
         dat_rd_ff <= nxt_dat_rd;
         index_ff <= nxt_index;
         last_ep_ff <= nxt_last_ep;
         tx_valid_ff <= nxt_tx_valid;
         tx_kind_ff <= nxt_tx_kind;
         tx_ep_ff <= nxt_tx_ep;
         tx_toggle_ff <= nxt_tx_toggle;
         ep_int_ff <= ep_irq;
         in_en_ff <= ep_in;
         out_en_ff <= ep_out;
         adr_rd_ff <= {nxt_acc != UIEC_ACC_IDLE, 1'b0, nxt_target};
      end
   end

endmodule

`default_nettype wire

// file: test/uiec_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module uiec_top_asserts
   import uiec_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic adr_wr,
   input wire logic dat_wr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] adr_rd_ff,
   input wire logic [7:0] dat_rd_ff,
   input wire logic in_token,
   input wire logic [3:0] in_token_ep,
   input wire logic tx_valid_ff,
   input wire uiec_tx_t tx_kind_ff,
   input wire logic [1:0] tx_ep_ff,
   input wire logic [2:0] ep_int_ff,
   input wire logic [2:0] in_en_ff
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic busy;
   logic ep_ok;
   assign busy = adr_rd_ff[7];
   // short-circuit keeps the index out of range only when ep_ok is already false
   assign ep_ok = (in_token_ep inside {4'h1, 4'h2, 4'h3}) && in_en_ff[in_token_ep[1:0] - 2'h1];
   data_busy_a: assert property (dat_wr && !adr_wr && !busy |=> busy ##1 !busy)
      else $error("data write busy window wrong");
   read_busy_a: assert property (adr_wr && wdata[6] && !busy |=> busy ##1 !busy)
      else $error("read busy window wrong");
   busy_short_a: assert property (busy |=> !busy)
      else $error("busy held too long");
   addr_load_a: assert property (adr_wr && !busy |=> adr_rd_ff[5:0] == $past(wdata[5:0]))
      else $error("target not loaded");
   addr_hold_a: assert property ($changed(adr_rd_ff[5:0]) |-> $past(adr_wr) && !$past(busy))
      else $error("target changed without write");
   rdata_hold_a: assert property ($changed(dat_rd_ff) |-> $fell(busy))
      else $error("read data changed off completion");
   tx_cause_a: assert property (tx_valid_ff |-> $past(in_token) && {2'h0, tx_ep_ff} + 4'h1 == $past(in_token_ep))
      else $error("answer without matching token");
   tx_refuse_a: assert property (in_token && !ep_ok |=> !tx_valid_ff)
      else $error("disabled endpoint answered");
   tx_int_a: assert property (tx_valid_ff && tx_kind_ff != UIEC_TX_NAK |-> ep_int_ff[tx_ep_ff])
      else $error("no interrupt with answer");
   cover property (tx_valid_ff && tx_kind_ff == UIEC_TX_ZLP);
   cover property (tx_valid_ff && tx_kind_ff == UIEC_TX_DATA);
   cover property (tx_valid_ff && tx_kind_ff == UIEC_TX_STALL);
endmodule
bind uiec_top uiec_top_asserts chk_i (.clk(clk), .arst_n(arst_n), .adr_wr(adr_wr), .dat_wr(dat_wr),
   .wdata(wdata), .adr_rd_ff(adr_rd_ff), .dat_rd_ff(dat_rd_ff), .in_token(in_token),
   .in_token_ep(in_token_ep), .tx_valid_ff(tx_valid_ff), .tx_kind_ff(tx_kind_ff), .tx_ep_ff(tx_ep_ff),
   .ep_int_ff(ep_int_ff), .in_en_ff(in_en_ff));
`default_nettype wire

// file: test/uiec_host.sv
`timescale 1ns/1ps
`default_nettype none
module uiec_host
   import uiec_pkg::*;
(
   input wire logic clk,
   output logic in_token,
   output logic [3:0] in_token_ep,
   output logic host_ack,
   input wire logic tx_valid_ff,
   input wire uiec_tx_t tx_kind_ff,
   input wire logic tx_toggle_ff
);
   initial begin
      in_token = 1'b0;
      in_token_ep = 4'hF;
      host_ack = 1'b0;
   end
   // endpoint lines scrambled while idle so a stale number never looks valid
   task automatic tok(input logic [3:0] ep, output logic v, output uiec_tx_t k, output logic t);
      @(negedge clk);
      in_token = 1'b1;
      in_token_ep = ep;
      @(negedge clk);
      in_token = 1'b0;
      in_token_ep = ~ep;
      v = tx_valid_ff;
      k = tx_kind_ff;
      t = tx_toggle_ff;
   endtask
   task automatic ack(input int gap);
      repeat (gap) @(negedge clk);
      @(negedge clk);
      host_ack = 1'b1;
      @(negedge clk);
      host_ack = 1'b0;
   endtask
endmodule
`default_nettype wire

// file: test/usb_in_endpoint_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module usb_in_endpoint_control_tb;
   import uiec_pkg::*;
   logic clk, arst_n, adr_wr, dat_wr, in_token, host_ack, tx_valid_ff, tx_toggle_ff, v, t;
   logic [7:0] wdata, adr_rd_ff, dat_rd_ff;
   logic [3:0] in_token_ep;
   logic [2:0] fifo_loaded, ep_int_ff, in_en_ff, out_en_ff;
   logic [1:0] tx_ep_ff;
   uiec_tx_t tx_kind_ff, k;
   int err_total, num_checks, icnt;
   uiec_top dut (.clk(clk), .arst_n(arst_n), .adr_wr(adr_wr), .dat_wr(dat_wr), .wdata(wdata),
      .adr_rd_ff(adr_rd_ff), .dat_rd_ff(dat_rd_ff), .in_token(in_token), .in_token_ep(in_token_ep),
      .host_ack(host_ack), .fifo_loaded(fifo_loaded), .tx_valid_ff(tx_valid_ff), .tx_kind_ff(tx_kind_ff),
      .tx_ep_ff(tx_ep_ff), .tx_toggle_ff(tx_toggle_ff), .ep_int_ff(ep_int_ff), .in_en_ff(in_en_ff),
      .out_en_ff(out_en_ff));
   uiec_host host (.clk(clk), .in_token(in_token), .in_token_ep(in_token_ep), .host_ack(host_ack),
      .tx_valid_ff(tx_valid_ff), .tx_kind_ff(tx_kind_ff), .tx_toggle_ff(tx_toggle_ff));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) if (ep_int_ff[0] === 1'b1) icnt <= icnt + 1;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("checks=%0d mismatches=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // polls busy after each request; bounded so a stuck busy cannot hang
   task automatic req(input logic adr, input logic [7:0] d);
      @(negedge clk);
      adr_wr = adr;
      dat_wr = !adr;
      wdata = d;
      @(negedge clk);
      adr_wr = 1'b0;
      dat_wr = 1'b0;
      for (int i = 0; i < 8 && adr_rd_ff[7] !== 1'b0; i++) @(negedge clk);
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      req(1'b1, {2'h0, a});
      req(1'b0, d);
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      req(1'b1, {2'h1, a});
      chk(dat_rd_ff, exp);
   endtask
   task automatic tokc(input logic [3:0] ep, input logic ev, input uiec_tx_t ek, input logic et);
      host.tok(ep, v, k, t);
      chk({7'h0, v}, {7'h0, ev});
      if (ev) chk({6'h0, k}, {6'h0, ek});
      if (ev && (ek == UIEC_TX_DATA || ek == UIEC_TX_ZLP)) chk({7'h0, t}, {7'h0, et});
   endtask
   initial begin
      #50000;
      err_total++;
      $display("watchdog expired");
      summarize();
   end
   initial begin
      arst_n = 1'b0;
      adr_wr = 1'b0;
      dat_wr = 1'b0;
      wdata = 8'h00;
      fifo_loaded = 3'h0;
      repeat (2) @(negedge clk);
      arst_n = 1'b1;
      repeat (3) @(negedge clk);
      rd(6'h0E, 8'h00);
      wr(6'h0E, 8'hF1);
      rd(6'h0E, 8'h01);
      rd(6'h3F, 8'h00);
      chk({5'h0, out_en_ff}, 8'h07);
      tokc(4'h1, 1'b0, UIEC_TX_NAK, 1'b0);
      wr(6'h12, 8'h20);
      // pipe enables are registered one edge after the control write lands
      @(negedge clk);
      chk({5'h0, in_en_ff}, 8'h01);
      chk({5'h0, out_en_ff}, 8'h06);
      wr(6'h0E, 8'h02);
      wr(6'h12, 8'h04);
      rd(6'h12, 8'h04);
      chk({5'h0, in_en_ff}, 8'h03);
      chk({5'h0, out_en_ff}, 8'h06);
      tokc(4'h4, 1'b0, UIEC_TX_NAK, 1'b0);
      wr(6'h0E, 8'h01);
      $display("config test done");
      wr(6'h11, 8'h01);
      tokc(4'h1, 1'b1, UIEC_TX_ZLP, 1'b0);
      rd(6'h11, 8'h00);
      fifo_loaded = 3'h1;
      wr(6'h11, 8'h01);
      tokc(4'h1, 1'b1, UIEC_TX_DATA, 1'b0);
      wr(6'h11, 8'h01);
      tokc(4'h1, 1'b1, UIEC_TX_DATA, 1'b0);
      host.ack(2);
      wr(6'h11, 8'h01);
      tokc(4'h1, 1'b1, UIEC_TX_DATA, 1'b1);
      tokc(4'h1, 1'b1, UIEC_TX_NAK, 1'b0);
      wr(6'h12, 8'h28);
      wr(6'h11, 8'h01);
      tokc(4'h1, 1'b1, UIEC_TX_DATA, 1'b1);
      wr(6'h11, 8'h01);
      tokc(4'h1, 1'b1, UIEC_TX_DATA, 1'b0);
      wr(6'h12, 8'h60);
      wr(6'h11, 8'h01);
      tokc(4'h1, 1'b1, UIEC_TX_DATA, 1'b1);
      host.ack(0);
      chk(icnt[7:0], 8'h07);
      $display("toggle test done");
      wr(6'h12, 8'hA0);
      wr(6'h11, 8'h01);
      rd(6'h11, 8'h02);
      wr(6'h11, 8'h01);
      rd(6'h11, 8'h03);
      chk(icnt[7:0], 8'h07);
      tokc(4'h1, 1'b1, UIEC_TX_DATA, 1'b1);
      rd(6'h11, 8'h02);
      wr(6'h11, 8'h08);
      rd(6'h11, 8'h00);
      chk(icnt[7:0], 8'h09);
      wr(6'h11, 8'h08);
      chk(icnt[7:0], 8'h09);
      $display("buffer test done");
      wr(6'h11, 8'h10);
      tokc(4'h1, 1'b1, UIEC_TX_STALL, 1'b0);
      rd(6'h11, 8'h30);
      wr(6'h11, 8'h10);
      rd(6'h11, 8'h10);
      tokc(4'h1, 1'b1, UIEC_TX_STALL, 1'b0);
      // the interrupt pulse is counted one edge after the answer
      @(negedge clk);
      chk(icnt[7:0], 8'h0B);
      wr(6'h11, 8'h00);
      $display("stall test done");
      summarize();
   end
endmodule
`default_nettype wire
